// ==== verilog/pmc_map.vh ====
// Register map, field positions and reset values of the power mode controller
`ifndef PMC_MAP_VH
`define PMC_MAP_VH

// ==========================================================
// Register byte offsets
`define PMC_ADDR_W 5
`define PMC_OFF_CTRL 5'h00
`define PMC_OFF_STATUS 5'h04
`define PMC_OFF_WAKE 5'h08
`define PMC_OFF_ISTAT 5'h0C
`define PMC_OFF_IMASK 5'h10

// ==========================================================
// Control fields
`define PMC_CTRL_IDLE 0
`define PMC_CTRL_PDOWN 1
`define PMC_CTRL_POF 2

// ==========================================================
// Wake configuration fields
`define PMC_WAKE_EN0 0
`define PMC_WAKE_EN1 1
`define PMC_WAKE_LVL0 2
`define PMC_WAKE_LVL1 3

// ==========================================================
// Interrupt event bits
`define PMC_EV_W 5
`define PMC_EV_IDLE 0
`define PMC_EV_PDOWN 1
`define PMC_EV_WAKE_IRQ 2
`define PMC_EV_WAKE_RST 3
`define PMC_EV_EMUL 4

// ==========================================================
// Reset values
`define PMC_POF_RST 1'h1
`define PMC_WAKE_RST 4'h0
`define PMC_IMASK_RST 5'h00

// ==========================================================
// Timing
`define PMC_MC_CLKS 12
`define PMC_GRACE_MC 2

`endif

// ==== verilog/pmc_power_mode_control.v ====
// Power mode controller: idle, power-down, wake-up, power-on flag, emulation entry
// Behaviour
// - State survives a slowed or stopped clock
// - Idle stops core, peripherals keep running
// - Idle entered after requesting instruction; state kept
// - Idle ends by enabled interrupt or reset
// - Power-down halts oscillator after requesting instruction
// - Reset exit reinitialises registers, keeps RAM
// - Interrupt exit keeps registers and RAM
// - Only enabled level-triggered external pins wake
// - Low restarts oscillator, high completes exit
// - After interrupt return, continue past entry
// - Power-on flag set by supply, software writable
// - Reset from idle blocks RAM writes briefly
// - Emulation entered by strobes at reset release
// - Emulation floats port 0, pulls, oscillator runs
// - Strobe and port states in low-power modes
`timescale 1ns/1ps
`include "pmc_map.vh"

module pmc_power_mode_control #(
  parameter MC_CLKS = `PMC_MC_CLKS,
  parameter GRACE_MC = `PMC_GRACE_MC
) (
  input wire i_clk_sys, // System clock
  input wire i_rst_n, // Power-on reset, async, low
  input wire i_hw_rst, // Reset pin, high active
  input wire i_supply_ramp, // Supply rose from zero, pulse
  input wire i_instr_done, // Core retired an instruction, pulse
  input wire i_irq_pending, // Any enabled interrupt pending
  input wire i_osc_stable, // Oscillator has settled
  input wire i_ext_program, // Executing from external memory
  input wire i_ext_irq_zero_n, // External interrupt pin 0
  input wire i_ext_irq_one_n, // External interrupt pin 1
  input wire i_core_ale, // Core address latch strobe
  input wire i_core_fetch_n, // Core program fetch strobe
  input wire i_ale_pin, // Address latch strobe pin level
  input wire i_program_fetch_strobe_n, // Fetch strobe pin level
  input wire i_wb_cyc, // Wishbone cycle
  input wire i_wb_stb, // Wishbone strobe
  input wire i_wb_we, // Wishbone write
  input wire [3:0] i_wb_sel, // Wishbone byte select
  input wire [`PMC_ADDR_W-1:0] i_wb_adr, // Wishbone byte address
  input wire [31:0] i_wb_dat, // Wishbone write data
  output reg [31:0] o_wb_dat, // Wishbone read data
  output reg o_wb_ack, // Wishbone acknowledge
  output reg o_irq, // Level interrupt
  output reg o_core_run, // Core clock enable
  output reg o_periph_run, // Peripheral clock enable
  output reg o_osc_en, // Oscillator enable
  output reg o_core_reset, // Core and register reset
  output reg o_ram_wr_block, // Internal RAM write inhibit
  output reg o_wake_irq, // Wake by interrupt, pulse
  output reg [1:0] o_wake_src, // Pin that woke the device
  output reg o_emul_mode, // Emulation mode active
  output reg o_ale_out, // Address latch strobe drive value
  output reg o_ale_oe, // Address latch strobe driven
  output reg o_program_fetch_strobe_n, // Fetch strobe drive value
  output reg o_program_fetch_strobe_n_oe, // Fetch strobe driven
  output reg o_strobe_pull, // Weak pull-up on strobes
  output reg o_port0_float, // Port 0 released
  output reg o_port_pull, // Ports 1 to 3 weak pull only
  output reg o_port2_addr // Port 2 drives address
);

  // ==========================================================
  // States
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_PDOWN = 3'h2;
  localparam [2:0] ST_WAKE = 3'h3;
  localparam [2:0] ST_GRACE = 3'h4;
  localparam [2:0] ST_RESET = 3'h5;
  localparam integer GRACE_CLKS = MC_CLKS * GRACE_MC;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [15:0] grace_cnt_r;
  reg idle_req_r;
  reg pdown_req_r;
  reg pof_r;
  reg [3:0] wake_cfg_r;
  reg [`PMC_EV_W-1:0] istat_r;
  reg [`PMC_EV_W-1:0] imask_r;
  reg emul_r;
  reg emul_arm_r;
  reg [1:0] src_r;
  reg [`PMC_EV_W-1:0] ev;
  reg [31:0] rd_mux;

  // ==========================================================
  // Bus decode
  wire acc = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // Write lands at the edge where the master samples ack high
  wire wr = i_wb_cyc & i_wb_stb & o_wb_ack & i_wb_we & i_wb_sel[0];
  wire wr_ctrl = wr & (i_wb_adr == `PMC_OFF_CTRL);
  wire wr_wake = wr & (i_wb_adr == `PMC_OFF_WAKE);
  wire wr_istat = wr & (i_wb_adr == `PMC_OFF_ISTAT);
  wire wr_imask = wr & (i_wb_adr == `PMC_OFF_IMASK);

  // Pin can wake only when enabled and level-sensitive
  wire arm0 = wake_cfg_r[`PMC_WAKE_EN0] & wake_cfg_r[`PMC_WAKE_LVL0];
  wire arm1 = wake_cfg_r[`PMC_WAKE_EN1] & wake_cfg_r[`PMC_WAKE_LVL1];
  wire low0 = arm0 & ~i_ext_irq_zero_n;
  wire low1 = arm1 & ~i_ext_irq_one_n;
  wire pins_high = (~arm0 | i_ext_irq_zero_n) & (~arm1 | i_ext_irq_one_n);

  // ==========================================================
  // Mode sequencer
  always @* begin
    state_nxt = state_r;
    ev = {`PMC_EV_W{1'b0}};
    case (state_r)
      ST_RUN: begin
        if (i_hw_rst) begin
          state_nxt = ST_RESET;
        end else if (i_instr_done & pdown_req_r & ~emul_r) begin
          // Power-down wins over a simultaneous idle request
          state_nxt = ST_PDOWN;
          ev[`PMC_EV_PDOWN] = 1'b1;
        end else if (i_instr_done & idle_req_r) begin
          state_nxt = ST_IDLE;
          ev[`PMC_EV_IDLE] = 1'b1;
        end
      end
      ST_IDLE: begin
        if (i_hw_rst) begin
          state_nxt = ST_GRACE;
        end else if (i_irq_pending) begin
          state_nxt = ST_RUN;
          ev[`PMC_EV_WAKE_IRQ] = 1'b1;
        end
      end
      ST_PDOWN: begin
        if (i_hw_rst) begin
          state_nxt = ST_RESET;
          ev[`PMC_EV_WAKE_RST] = 1'b1;
        end else if (low0 | low1) begin
          state_nxt = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (i_hw_rst) begin
          state_nxt = ST_RESET;
          ev[`PMC_EV_WAKE_RST] = 1'b1;
        end else if (pins_high & i_osc_stable) begin
          // Registers untouched, core vectors to the pin's handler
          state_nxt = ST_RUN;
          ev[`PMC_EV_WAKE_IRQ] = 1'b1;
        end
      end
      ST_GRACE: begin
        if (grace_cnt_r == 16'h0000) begin
          state_nxt = ST_RESET;
          ev[`PMC_EV_WAKE_RST] = 1'b1;
        end
      end
      ST_RESET: begin
        if (~i_hw_rst) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_RESET;
      end
    endcase
  end

  // Flops keep their value with no edge, so a stopped clock loses nothing
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_RUN;
      grace_cnt_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && state_nxt == ST_GRACE) begin
        grace_cnt_r <= GRACE_CLKS[15:0] - 16'h0001;
      end else if (grace_cnt_r != 16'h0000) begin
        grace_cnt_r <= grace_cnt_r - 16'h0001;
      end
    end
  end

  // ==========================================================
  // Emulation entry, caught at the reset pin release
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      emul_r <= 1'b0;
      emul_arm_r <= 1'b0;
    end else if (state_r == ST_RESET) begin
      if (i_hw_rst) begin
        // Strobe low while fetch strobe high, during reset
        emul_arm_r <= ~i_ale_pin & i_program_fetch_strobe_n;
      end else begin
        // Still low at release enters, otherwise normal reset clears it
        emul_r <= emul_arm_r & ~i_ale_pin;
        emul_arm_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Software registers
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idle_req_r <= 1'b0;
      pdown_req_r <= 1'b0;
      pof_r <= `PMC_POF_RST;
      wake_cfg_r <= `PMC_WAKE_RST;
      imask_r <= `PMC_IMASK_RST;
      src_r <= 2'h0;
    end else begin
      // Supply detection wins over a software write in the same cycle
      if (i_supply_ramp) begin
        pof_r <= 1'b1;
      end else if (wr_ctrl) begin
        pof_r <= i_wb_dat[`PMC_CTRL_POF];
      end
      if (state_r == ST_RESET) begin
        // Reset pin reinitialises control, wake and mask registers; flag and event status survive a warm start
        idle_req_r <= 1'b0;
        pdown_req_r <= 1'b0;
        wake_cfg_r <= `PMC_WAKE_RST;
        imask_r <= `PMC_IMASK_RST;
      end else begin
        if (state_nxt != ST_RUN && state_r == ST_RUN) begin
          idle_req_r <= 1'b0;
          pdown_req_r <= 1'b0;
        end else if (wr_ctrl) begin
          idle_req_r <= i_wb_dat[`PMC_CTRL_IDLE];
          pdown_req_r <= i_wb_dat[`PMC_CTRL_PDOWN];
        end
        if (wr_wake) begin
          wake_cfg_r <= i_wb_dat[3:0];
        end
        if (wr_imask) begin
          imask_r <= i_wb_dat[`PMC_EV_W-1:0];
        end
      end
      if (state_r == ST_PDOWN && state_nxt == ST_WAKE) begin
        src_r <= {low1, low0};
      end
    end
  end

  // Sticky events; a new event beats a clearing write
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      istat_r <= {`PMC_EV_W{1'b0}};
    end else begin
      istat_r <= (istat_r & ~(wr_istat ? i_wb_dat[`PMC_EV_W-1:0] : {`PMC_EV_W{1'b0}}))
                 | ev | {(emul_r == 1'b0 && state_r == ST_RESET && ~i_hw_rst
                          && emul_arm_r && ~i_ale_pin), {(`PMC_EV_W-1){1'b0}}};
    end
  end

  // ==========================================================
  // Read mux; unmapped offsets read as zero
  always @* begin
    rd_mux = 32'h0000_0000;
    case (i_wb_adr)
      `PMC_OFF_CTRL: begin
        rd_mux[`PMC_CTRL_IDLE] = idle_req_r;
        rd_mux[`PMC_CTRL_PDOWN] = pdown_req_r;
        rd_mux[`PMC_CTRL_POF] = pof_r;
      end
      `PMC_OFF_STATUS: begin
        rd_mux[2:0] = state_r;
        rd_mux[3] = emul_r;
        rd_mux[5:4] = src_r;
      end
      `PMC_OFF_WAKE: begin
        rd_mux[3:0] = wake_cfg_r;
      end
      `PMC_OFF_ISTAT: begin
        rd_mux[`PMC_EV_W-1:0] = istat_r;
      end
      `PMC_OFF_IMASK: begin
        rd_mux[`PMC_EV_W-1:0] = imask_r;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
      o_irq <= 1'b0;
    end else begin
      o_wb_ack <= acc;
      if (acc) begin
        o_wb_dat <= rd_mux;
      end
      o_irq <= |(istat_r & imask_r);
    end
  end

  // ==========================================================
  // Clock enables, reset and pin states, registered from the next state
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_run <= 1'b0;
      o_periph_run <= 1'b0;
      o_osc_en <= 1'b1;
      o_core_reset <= 1'b1;
      o_ram_wr_block <= 1'b0;
      o_wake_irq <= 1'b0;
      o_wake_src <= 2'h0;
      o_emul_mode <= 1'b0;
      o_ale_out <= 1'b1;
      o_ale_oe <= 1'b0;
      o_program_fetch_strobe_n <= 1'b1;
      o_program_fetch_strobe_n_oe <= 1'b0;
      o_strobe_pull <= 1'b1;
      o_port0_float <= 1'b1;
      o_port_pull <= 1'b1;
      o_port2_addr <= 1'b0;
    end else begin
      // Core halts in both low-power modes; peripherals only in power-down
      o_core_run <= (state_nxt == ST_RUN) | (state_nxt == ST_GRACE);
      o_periph_run <= (state_nxt != ST_PDOWN) & (state_nxt != ST_WAKE);
      // Oscillator stops only in power-down, never in emulation
      o_osc_en <= (state_nxt != ST_PDOWN) | emul_r;
      o_core_reset <= (state_nxt == ST_RESET);
      // Port pins stay writable during the grace period, RAM does not
      o_ram_wr_block <= (state_nxt == ST_GRACE) | (state_nxt == ST_RESET);
      o_wake_irq <= ev[`PMC_EV_WAKE_IRQ];
      o_wake_src <= ((state_r == ST_WAKE) & ev[`PMC_EV_WAKE_IRQ]) ? src_r : 2'h0;
      o_emul_mode <= emul_r;
      if (emul_r) begin
        // Emulator drives the board; only weak pull-ups remain
        o_ale_oe <= 1'b0;
        o_program_fetch_strobe_n_oe <= 1'b0;
        o_ale_out <= 1'b1;
        o_program_fetch_strobe_n <= 1'b1;
        o_strobe_pull <= 1'b1;
        o_port0_float <= 1'b1;
        o_port_pull <= 1'b1;
        o_port2_addr <= 1'b0;
      end else begin
        o_ale_oe <= 1'b1;
        o_program_fetch_strobe_n_oe <= 1'b1;
        o_strobe_pull <= 1'b0;
        o_port_pull <= 1'b0;
        case (state_nxt)
          ST_IDLE: begin
            o_ale_out <= 1'b1;
            o_program_fetch_strobe_n <= 1'b1;
            o_port0_float <= i_ext_program;
            o_port2_addr <= i_ext_program;
          end
          ST_PDOWN, ST_WAKE: begin
            o_ale_out <= 1'b0;
            o_program_fetch_strobe_n <= 1'b0;
            o_port0_float <= i_ext_program;
            o_port2_addr <= 1'b0;
          end
          default: begin
            o_ale_out <= i_core_ale;
            o_program_fetch_strobe_n <= i_core_fetch_n;
            o_port0_float <= 1'b0;
            o_port2_addr <= i_ext_program;
          end
        endcase
      end
    end
  end

endmodule

// ==== dv/pmc_wake_partner.sv ====
// Behavioural far side: wake-up pins, oscillator settling and emulator probe
`timescale 1ns/1ps
module pmc_wake_partner #(
  parameter SETTLE = 8
) (
  input wire i_clk_sys, // System clock
  input wire i_osc_en, // Oscillator enable from block
  input wire [1:0] i_wake_req, // Bench asks a pin to go low
  input wire i_emul_req, // Bench asks the emulator to pull ALE low
  input wire i_ale_out, // Strobe drive value
  input wire i_ale_oe, // Strobe driven
  input wire i_fetch_n, // Fetch strobe drive value
  input wire i_fetch_oe, // Fetch strobe driven
  output wire o_irq0_n, // Wake pin 0
  output wire o_irq1_n, // Wake pin 1
  output reg o_osc_stable = 1'b0, // Oscillator settled
  output wire o_ale_pin, // Sensed strobe level
  output wire o_fetch_pin // Sensed fetch strobe level
);
  // ==========================================================
  // Oscillator settling and pin holding
  integer cnt = 0;
  reg [1:0] low_r = 2'h0;
  always @(posedge i_clk_sys) begin
    cnt <= i_osc_en ? cnt + 1 : 0;
    o_osc_stable <= i_osc_en && cnt >= SETTLE;
    // Pin stays low until the oscillator is stable, then returns high
    low_r <= i_wake_req | (low_r & {2{~o_osc_stable}});
  end
  assign o_irq0_n = ~low_r[0];
  assign o_irq1_n = ~low_r[1];
  // Emulator overdrives the strobe; released strobes sit on their pull-ups
  assign o_ale_pin = i_emul_req ? 1'b0 : (i_ale_oe ? i_ale_out : 1'b1);
  assign o_fetch_pin = i_fetch_oe ? i_fetch_n : 1'b1;
endmodule

// ==== dv/pmc_power_mode_control_assertions.sv ====
// Port-level checks of the power mode controller
`timescale 1ns/1ps
module pmc_checker #(
  parameter MC_CLKS = 12,
  parameter GRACE_MC = 2
) (
  input wire i_clk_sys, i_rst_n, i_hw_rst, i_wb_cyc, i_wb_stb, o_wb_ack,
  input wire o_core_run, o_periph_run, o_osc_en, o_core_reset, o_ram_wr_block,
  input wire o_wake_irq, o_emul_mode, o_ale_out, o_ale_oe, o_program_fetch_strobe_n,
  input wire [1:0] o_wake_src,
  input wire o_program_fetch_strobe_n_oe, o_strobe_pull, o_port0_float,
  input wire o_port_pull, o_port2_addr
);
  // ==========================================================
  // Assertions
  localparam int GRACE_MAX = MC_CLKS * GRACE_MC + 6;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  AST_ACK_LAT: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not answered next cycle");
  AST_ACK_PULSE: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  AST_PD_STROBES: assert property (!o_osc_en |-> !o_ale_out && !o_program_fetch_strobe_n)
    else $error("strobes not low in power-down");
  AST_PD_CORE: assert property (!o_osc_en |-> !o_core_run && !o_periph_run)
    else $error("logic runs with oscillator stopped");
  AST_PD_PORT2: assert property (!o_osc_en |-> !o_port2_addr)
    else $error("port 2 drives address in power-down");
  AST_EMUL: assert property (o_emul_mode |-> o_port0_float && o_port_pull && o_strobe_pull
    && o_osc_en && !o_ale_oe && !o_program_fetch_strobe_n_oe)
    else $error("emulation pin states wrong");
  AST_WAKE_SRC: assert property (!o_wake_irq |-> o_wake_src == 2'h0)
    else $error("wake source shown without wake pulse");
  AST_WAKE_PULSE: assert property (o_wake_irq |=> !o_wake_irq)
    else $error("wake pulse longer than one cycle");
  AST_GRACE: assert property (o_ram_wr_block && o_core_run |=> o_ram_wr_block)
    else $error("RAM write block dropped during grace");
  AST_HWRST: assert property (i_hw_rst [*2] |-> ##[0:GRACE_MAX] o_core_reset)
    else $error("hardware reset not applied in time");
  cover property (o_wake_irq && o_wake_src != 2'h0);
  cover property (o_emul_mode);
  cover property (o_ram_wr_block && o_core_run);
endmodule

bind pmc_power_mode_control pmc_checker #(.MC_CLKS(MC_CLKS), .GRACE_MC(GRACE_MC)) pmc_checker_i (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_hw_rst(i_hw_rst), .i_wb_cyc(i_wb_cyc),
  .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_core_run(o_core_run),
  .o_periph_run(o_periph_run), .o_osc_en(o_osc_en), .o_core_reset(o_core_reset),
  .o_ram_wr_block(o_ram_wr_block), .o_wake_irq(o_wake_irq), .o_emul_mode(o_emul_mode),
  .o_ale_out(o_ale_out), .o_ale_oe(o_ale_oe), .o_wake_src(o_wake_src),
  .o_program_fetch_strobe_n(o_program_fetch_strobe_n),
  .o_program_fetch_strobe_n_oe(o_program_fetch_strobe_n_oe), .o_strobe_pull(o_strobe_pull),
  .o_port0_float(o_port0_float), .o_port_pull(o_port_pull), .o_port2_addr(o_port2_addr));

// ==== dv/pmc_power_mode_control_tb.sv ====
// Self-checking bench of the power mode controller
`timescale 1ns/1ps
`include "pmc_map.vh"
module pmc_power_mode_control_tb;
  reg clk = 1'b0, rst_n = 1'b0, hw_rst = 1'b0, supply = 1'b0, instr = 1'b0, irqp = 1'b0;
  reg cyc = 1'b0, stb = 1'b0, we = 1'b0, emul_req = 1'b0;
  reg ext_prog = 1'b1;
  reg [3:0] sel = 4'h0;
  reg [1:0] wake_req = 2'h0;
  reg [4:0] adr = 5'h00;
  reg [31:0] wdat = 32'h0, rdat;
  integer n_errors = 0, compares = 0, cycles = 0;
  wire [31:0] o_dat;
  wire [1:0] wsrc;
  wire ack, irq, crun, prun, osc, creset, rblk, wirq, emul, alo, aloe, fo, foe, p0f, p2a;
  wire irq0_n, irq1_n, stable, ale_pin, fetch_pin, ppull, spull;
  always #5 clk = ~clk;

  pmc_power_mode_control pmc_power_mode_control_i (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_hw_rst(hw_rst), .i_supply_ramp(supply),
    .i_instr_done(instr), .i_irq_pending(irqp), .i_osc_stable(stable), .i_ext_program(ext_prog),
    .i_ext_irq_zero_n(irq0_n), .i_ext_irq_one_n(irq1_n), .i_core_ale(1'b1),
    .i_core_fetch_n(1'b1), .i_ale_pin(ale_pin), .i_program_fetch_strobe_n(fetch_pin),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_sel(sel), .i_wb_adr(adr),
    .i_wb_dat(wdat), .o_wb_dat(o_dat), .o_wb_ack(ack), .o_irq(irq), .o_core_run(crun),
    .o_periph_run(prun), .o_osc_en(osc), .o_core_reset(creset), .o_ram_wr_block(rblk),
    .o_wake_irq(wirq), .o_wake_src(wsrc), .o_emul_mode(emul), .o_ale_out(alo),
    .o_ale_oe(aloe), .o_program_fetch_strobe_n(fo), .o_program_fetch_strobe_n_oe(foe),
    .o_strobe_pull(spull), .o_port0_float(p0f), .o_port_pull(ppull), .o_port2_addr(p2a));

  pmc_wake_partner pmc_wake_partner_i (
    .i_clk_sys(clk), .i_osc_en(osc), .i_wake_req(wake_req), .i_emul_req(emul_req),
    .i_ale_out(alo), .i_ale_oe(aloe), .i_fetch_n(fo), .i_fetch_oe(foe), .o_irq0_n(irq0_n),
    .o_irq1_n(irq1_n), .o_osc_stable(stable), .o_ale_pin(ale_pin), .o_fetch_pin(fetch_pin));

  // ==========================================================
  // Tasks
  task wrap_up;
    begin
      if (n_errors == 0 && compares > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // Held until ack is sampled; released only at that edge
  task bus(input w, input [4:0] a, input [31:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'hF;
      adr <= a;
      wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      rdat = o_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      sel <= 4'h0;
    end
  endtask
  task rd(input [4:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk(rdat, exp);
    end
  endtask
  task step(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Entry instruction is followed by no port or external memory write
  task go;
    begin
      @(posedge clk) instr <= 1'b1;
      @(posedge clk) instr <= 1'b0;
      step(2);
    end
  endtask

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      n_errors = n_errors + 1;
      wrap_up;
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    step(5);
    rst_n <= 1'b1;
    rd(`PMC_OFF_CTRL, 32'h4);
    rd(`PMC_OFF_WAKE, 32'h0);
    rd(5'h14, 32'h0);
    bus(1'b1, `PMC_OFF_CTRL, 32'h0);
    rd(`PMC_OFF_CTRL, 32'h0);
    @(posedge clk) supply <= 1'b1;
    @(posedge clk) supply <= 1'b0;
    rd(`PMC_OFF_CTRL, 32'h4);
    bus(1'b1, `PMC_OFF_IMASK, 32'h1F);
    bus(1'b1, `PMC_OFF_CTRL, 32'h5);
    go;
    chk({crun, prun, alo, fo, p2a, p0f}, 32'h1F);
    rd(`PMC_OFF_STATUS, 32'h1);
    rd(`PMC_OFF_ISTAT, 32'h1);
    chk(irq, 32'h1);
    bus(1'b1, `PMC_OFF_ISTAT, 32'h1);
    step(2);
    chk(irq, 32'h0);
    @(posedge clk) irqp <= 1'b1;
    @(posedge clk);
    while (wirq !== 1'b1) @(posedge clk);
    irqp <= 1'b0;
    chk(wsrc, 32'h0);
    step(2);
    chk({crun, aloe, foe, ppull, spull}, 32'h1C);
    bus(1'b1, `PMC_OFF_WAKE, 32'h1);
    bus(1'b1, `PMC_OFF_CTRL, 32'h7);
    go;
    chk({osc, alo, fo, p2a, p0f}, 32'h1);
    rd(`PMC_OFF_STATUS, 32'h2);
    @(posedge clk) wake_req <= 2'h1;
    step(10);
    chk(osc, 32'h0);
    wake_req <= 2'h0;
    bus(1'b1, `PMC_OFF_WAKE, 32'hA);
    @(posedge clk) wake_req <= 2'h2;
    step(4);
    chk(osc, 32'h1);
    wake_req <= 2'h0;
    while (wirq !== 1'b1) @(posedge clk);
    chk(wsrc, 32'h2);
    rd(`PMC_OFF_WAKE, 32'hA);
    bus(1'b1, `PMC_OFF_ISTAT, 32'h1F);
    bus(1'b1, `PMC_OFF_CTRL, 32'h2);
    go;
    @(posedge clk) hw_rst <= 1'b1;
    step(3);
    chk(creset, 32'h1);
    hw_rst <= 1'b0;
    step(2);
    rd(`PMC_OFF_IMASK, 32'h0);
    rd(`PMC_OFF_ISTAT, 32'hA);
    rd(`PMC_OFF_CTRL, 32'h0);
    ext_prog <= 1'b0;
    bus(1'b1, `PMC_OFF_CTRL, 32'h1);
    go;
    chk({p0f, p2a}, 32'h0);
    @(posedge clk) hw_rst <= 1'b1;
    step(3);
    chk({crun, rblk, creset}, 32'h6);
    step(26);
    chk(creset, 32'h1);
    emul_req <= 1'b1;
    step(2);
    hw_rst <= 1'b0;
    step(3);
    emul_req <= 1'b0;
    step(2);
    chk({emul, p0f, ppull, spull, osc, aloe, foe}, 32'h7C);
    hw_rst <= 1'b1;
    step(3);
    hw_rst <= 1'b0;
    step(3);
    chk(emul, 32'h0);
    wrap_up;
  end
endmodule
